// File: mcfs_pkg.sv
// package of constants for the motion command frame slave
// assumes one 20 MHz clock; compiled before every design file of the block
package mcfs_pkg;
  // ------------------------------------------------------------
  // frame layout
  // ------------------------------------------------------------
  localparam int unsigned CORE_LEN   = 7;
  localparam int unsigned FRAME_LEN  = 9;
  localparam int unsigned VALUE_LEN  = 4;
  localparam logic [3:0]  IDX_ADDR   = 4'h0;
  localparam logic [3:0]  IDX_CMD    = 4'h1;
  localparam logic [3:0]  IDX_TYPE   = 4'h2;
  localparam logic [3:0]  IDX_BANK   = 4'h3;
  localparam logic [3:0]  IDX_VAL0   = 4'h4;
  localparam logic [3:0]  IDX_CSUM   = 4'h8;
  // ------------------------------------------------------------
  // status codes
  // ------------------------------------------------------------
  localparam logic [7:0] ST_OK       = 8'h64;
  localparam logic [7:0] ST_STORED   = 8'h65;
  localparam logic [7:0] ST_BAD_CSUM = 8'h01;
  localparam logic [7:0] ST_BAD_CMD  = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE = 8'h03;
  localparam logic [7:0] ST_BAD_VAL  = 8'h04;
  localparam logic [7:0] ST_LOCKED   = 8'h05;
  localparam logic [7:0] ST_NA       = 8'h06;
  // ------------------------------------------------------------
  // reset values and buffer
  // ------------------------------------------------------------
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned FIFO_WIDTH = 8;

  typedef enum logic [2:0] {
    MCFS_RX   = 3'b000,
    MCFS_EXEC = 3'b001,
    MCFS_WAIT = 3'b011,
    MCFS_TX   = 3'b010,
    MCFS_DONE = 3'b110
  } mcfs_state_t;
endpackage

// File: mcfs_fifo.sv
// synchronous flip-flop fifo with valid/ready on both sides
// assumes a single clock and asynchronous active-high reset
`timescale 1ns/1ps
module mcfs_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// File: mcfs_frame_slave.sv
// command frame parser and reply engine of the motion module slave
// assumes bytes arrive from a link receiver as one-cycle strobes, and that an
// executor outside answers each command with a done pulse, status and value
//
// Behaviour
// - every received command gets exactly one reply, after execution completes or, on a bad checksum, without execution
// - bus driver enabled only while a reply is being sent
// - nothing is transmitted unless a command was received first
// - core command is seven bytes: command, type, bank, four value bytes
// - byte links add an address byte and checksum byte: nine bytes
// - order: address, command, type, bank, value msb first, checksum
// - checksum is modulo-256 sum of all preceding bytes
// - can link omits address and checksum; identifier is the address
// - reply: reply address, module address, status, command, value, checksum
// - reply checksum is modulo-256 sum of the other reply bytes
// - can replies omit address and checksum bytes
// - status 100 on success, 101 when stored into program memory
// - error statuses 1 to 6 passed back for the listed faults
// - commands may be stored into program memory for standalone running
`timescale 1ns/1ps
module mcfs_frame_slave #(
  parameter int unsigned FIFO_DEPTH = mcfs_pkg::FIFO_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       can_mode,
  input  wire logic [7:0] module_addr,
  input  wire logic [7:0] reply_addr,
  input  wire logic       store_mode,
  input  wire logic [7:0] rx_byte,
  input  wire logic       rx_strobe,
  input  wire logic       rx_sof,
  output logic            cmd_valid,
  output logic      [7:0] cmd_number,
  output logic      [7:0] cmd_type,
  output logic      [7:0] cmd_bank,
  output logic     [31:0] cmd_value,
  output logic            cmd_store,
  input  wire logic       exec_done,
  input  wire logic [7:0] exec_status,
  input  wire logic [31:0] exec_value,
  output logic      [7:0] tx_byte,
  output logic            tx_valid,
  input  wire logic       tx_ready,
  output logic            tx_drive_en,
  output logic            frame_error
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] sum8(input logic [7:0] a, input logic [7:0] b);
    sum8 = a + b;
  endfunction

  function automatic logic [3:0] last_idx(input logic can);
    last_idx = can ? 4'(mcfs_pkg::CORE_LEN - 1) : 4'(mcfs_pkg::FRAME_LEN - 1);
  endfunction

  // can replies carry status, command and value only: no checksum slot
  function automatic logic [3:0] reply_last(input logic can);
    reply_last = can ? 4'(mcfs_pkg::VALUE_LEN + 1) : 4'(mcfs_pkg::FRAME_LEN - 1);
  endfunction

  // ------------------------------------------------------------
  // receive side
  // ------------------------------------------------------------
  mcfs_pkg::mcfs_state_t state_r;
  mcfs_pkg::mcfs_state_t state_nxt;
  logic [3:0]  rx_idx_r;
  logic [7:0]  rx_sum_r;
  logic [7:0]  f_cmd_r;
  logic [7:0]  f_type_r;
  logic [7:0]  f_bank_r;
  logic [31:0] f_val_r;
  logic        skip_r;
  logic [7:0]  r_status_r;
  logic [31:0] r_val_r;
  logic [3:0]  tx_idx_r;

  // a start-of-frame byte is itself byte 0, so index and sum restart under it
  wire [3:0] cur_idx   = rx_sof ? 4'h0 : rx_idx_r;
  wire [7:0] cur_sum   = rx_sof ? mcfs_pkg::RST_BYTE : rx_sum_r;
  // in can mode the first byte is the command, so shift the index by one
  wire [3:0] eff_idx   = can_mode ? cur_idx + 4'h1 : cur_idx;
  // a frame for another node is skipped up to the next start of frame
  wire       rx_take   = rx_strobe && (state_r == mcfs_pkg::MCFS_RX) && (rx_sof || !skip_r);
  wire       rx_last   = rx_take && (cur_idx == last_idx(can_mode));
  wire       csum_ok   = can_mode || (rx_byte == cur_sum);
  wire       addr_hit  = can_mode || (eff_idx != mcfs_pkg::IDX_ADDR) ||
                         (rx_byte == module_addr);

  // ------------------------------------------------------------
  // reply buffer fill side
  // ------------------------------------------------------------
  logic [7:0] fill_byte;
  logic [7:0] fill_sum_r;
  wire        fill_ready;
  wire        fill_valid = (state_r == mcfs_pkg::MCFS_TX);
  wire        fill_last  = (tx_idx_r == reply_last(can_mode));
  wire        fill_go    = fill_valid && fill_ready;
  wire [3:0]  tx_eff     = can_mode ? tx_idx_r + 4'h2 : tx_idx_r;

  always_comb begin
    case (tx_eff)
      4'h0:    fill_byte = reply_addr;
      4'h1:    fill_byte = module_addr;
      4'h2:    fill_byte = r_status_r;
      4'h3:    fill_byte = f_cmd_r;
      4'h4:    fill_byte = r_val_r[31:24];
      4'h5:    fill_byte = r_val_r[23:16];
      4'h6:    fill_byte = r_val_r[15:8];
      4'h7:    fill_byte = r_val_r[7:0];
      4'h8:    fill_byte = fill_sum_r;
      default: fill_byte = mcfs_pkg::RST_BYTE;
    endcase
  end

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      mcfs_pkg::MCFS_RX:   if (rx_last) begin
                             state_nxt = csum_ok ? mcfs_pkg::MCFS_EXEC
                                                 : mcfs_pkg::MCFS_TX;
                           end
      mcfs_pkg::MCFS_EXEC: state_nxt = mcfs_pkg::MCFS_WAIT;
      mcfs_pkg::MCFS_WAIT: if (exec_done) begin
                             state_nxt = mcfs_pkg::MCFS_TX;
                           end
      mcfs_pkg::MCFS_TX:   if (fill_go && fill_last) begin
                             state_nxt = mcfs_pkg::MCFS_DONE;
                           end
      mcfs_pkg::MCFS_DONE: if (!tx_valid && !tx_drive_en) begin
                             state_nxt = mcfs_pkg::MCFS_RX;
                           end
      default:             state_nxt = mcfs_pkg::MCFS_RX;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r    <= mcfs_pkg::MCFS_RX;
      rx_idx_r   <= '0;
      rx_sum_r   <= mcfs_pkg::RST_BYTE;
      f_cmd_r    <= mcfs_pkg::RST_BYTE;
      f_type_r   <= mcfs_pkg::RST_BYTE;
      f_bank_r   <= mcfs_pkg::RST_BYTE;
      f_val_r    <= '0;
      skip_r     <= 1'b0;
      frame_error <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      frame_error <= 1'b0;
      if (rx_take) begin
        skip_r <= !addr_hit;
        if (!addr_hit) begin
          rx_idx_r <= '0; // frame for another node: wait for next start
        end else if (rx_last) begin
          rx_idx_r    <= '0;
          rx_sum_r    <= mcfs_pkg::RST_BYTE;
          frame_error <= !csum_ok;
        end else begin
          rx_idx_r <= cur_idx + 4'h1;
          rx_sum_r <= sum8(cur_sum, rx_byte);
        end
        case (eff_idx)
          mcfs_pkg::IDX_CMD:  f_cmd_r  <= rx_byte;
          mcfs_pkg::IDX_TYPE: f_type_r <= rx_byte;
          mcfs_pkg::IDX_BANK: f_bank_r <= rx_byte;
          4'h4, 4'h5, 4'h6, 4'h7: f_val_r <= {f_val_r[23:0], rx_byte};
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // execution request and reply capture
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_valid  <= 1'b0;
      cmd_number <= mcfs_pkg::RST_BYTE;
      cmd_type   <= mcfs_pkg::RST_BYTE;
      cmd_bank   <= mcfs_pkg::RST_BYTE;
      cmd_value  <= '0;
      cmd_store  <= 1'b0;
      r_status_r <= mcfs_pkg::RST_BYTE;
      r_val_r    <= '0;
    end else begin
      cmd_valid <= (state_r == mcfs_pkg::MCFS_EXEC);
      if (state_r == mcfs_pkg::MCFS_EXEC) begin
        cmd_number <= f_cmd_r;
        cmd_type   <= f_type_r;
        cmd_bank   <= f_bank_r;
        cmd_value  <= f_val_r;
        cmd_store  <= store_mode;
      end
      if (rx_last && !csum_ok) begin
        r_status_r <= mcfs_pkg::ST_BAD_CSUM;
        r_val_r    <= '0;
      end else if (state_r == mcfs_pkg::MCFS_WAIT && exec_done) begin
        // stored commands answer 101 when the executor reports 100, else executor status
        r_status_r <= (cmd_store && exec_status == mcfs_pkg::ST_OK) ?
                      mcfs_pkg::ST_STORED : exec_status;
        r_val_r    <= exec_value;
      end
    end
  end

  // ------------------------------------------------------------
  // reply generation into the buffer
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_idx_r   <= '0;
      fill_sum_r <= mcfs_pkg::RST_BYTE;
    end else if (state_r != mcfs_pkg::MCFS_TX) begin
      tx_idx_r   <= '0;
      fill_sum_r <= mcfs_pkg::RST_BYTE;
    end else if (fill_go) begin
      tx_idx_r   <= tx_idx_r + 4'h1;
      fill_sum_r <= sum8(fill_sum_r, fill_byte);
    end
  end

  logic [7:0] buf_data;
  logic       buf_valid;
  wire        buf_pop = buf_valid && (!tx_valid || tx_ready);

  mcfs_fifo #(
    .WIDTH (mcfs_pkg::FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_reply_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (fill_byte),
    .in_valid  (fill_valid),
    .in_ready  (fill_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (!tx_valid || tx_ready)
  );

  // driver enabled only while reply bytes are pending
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_byte     <= mcfs_pkg::RST_BYTE;
      tx_valid    <= 1'b0;
      tx_drive_en <= 1'b0;
    end else begin
      if (buf_pop) begin
        tx_byte  <= buf_data;
        tx_valid <= 1'b1;
      end else if (tx_ready) begin
        tx_valid <= 1'b0;
      end
      tx_drive_en <= buf_pop || (tx_valid && !tx_ready) || buf_valid;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  reply_after_exec_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == mcfs_pkg::MCFS_WAIT && exec_done) |=> state_r == mcfs_pkg::MCFS_TX)
    else $error("reply not started after execution");
  tx_needs_drive_a: assert property (@(posedge clk) disable iff (rst)
    tx_valid |-> tx_drive_en)
    else $error("byte offered without bus drive");
  quiet_idle_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == mcfs_pkg::MCFS_RX && !buf_valid && !tx_valid) |=> !tx_valid)
    else $error("transmission without command");
  idle_no_drive_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == mcfs_pkg::MCFS_RX && !buf_valid && !tx_valid) |-> !tx_drive_en)
    else $error("bus driven while idle");
  bad_csum_skip_a: assert property (@(posedge clk) disable iff (rst)
    (rx_last && !csum_ok) |=> state_r == mcfs_pkg::MCFS_TX ##1 !cmd_valid)
    else $error("bad checksum frame executed");
  bad_csum_code_a: assert property (@(posedge clk) disable iff (rst)
    (rx_last && !csum_ok) |=> r_status_r == mcfs_pkg::ST_BAD_CSUM)
    else $error("wrong status for bad checksum");
  stored_code_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == mcfs_pkg::MCFS_WAIT && exec_done && cmd_store &&
     exec_status == mcfs_pkg::ST_OK) |=> r_status_r == mcfs_pkg::ST_STORED)
    else $error("stored command not answered 101");
  one_exec_a: assert property (@(posedge clk) disable iff (rst)
    cmd_valid |=> !cmd_valid)
    else $error("command issued twice");
  reply_len_a: assert property (@(posedge clk) disable iff (rst)
    (fill_go && fill_last) |->
    tx_eff == (can_mode ? mcfs_pkg::IDX_VAL0 + 4'h3 : mcfs_pkg::IDX_CSUM))
    else $error("reply length wrong");
  csum_last_a: assert property (@(posedge clk) disable iff (rst)
    (fill_go && tx_eff == mcfs_pkg::IDX_CSUM) |->
    fill_byte == 8'(reply_addr + module_addr + r_status_r + f_cmd_r + r_val_r[31:24] +
                    r_val_r[23:16] + r_val_r[15:8] + r_val_r[7:0]))
    else $error("reply checksum wrong");
endmodule

// File: mcfs_host_model.sv
// host model: sends command frames byte by byte and collects reply bytes
// assumes the slave's rx strobe port and tx valid/ready port on one clock
`timescale 1ns/1ps
module mcfs_host_model (
  input  wire logic       clk,
  output logic      [7:0] rx_byte,
  output logic            rx_strobe,
  output logic            rx_sof,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic       tx_drive_en
);
  logic [7:0] reply_q[$];

  initial begin
    rx_byte   = 8'h00;
    rx_strobe = 1'b0;
    rx_sof    = 1'b0;
    tx_ready  = 1'b0;
  end

  // ------------------------------------------------------------
  // frame out, first byte in bits 71:64
  // ------------------------------------------------------------
  task automatic send(input logic [71:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #2;
      rx_byte   = f[71-8*i -: 8];
      rx_strobe = 1'b1;
      rx_sof    = (i == 0);
    end
    @(posedge clk);
    #2;
    rx_strobe = 1'b0;
    rx_sof    = 1'b0;
    rx_byte   = ~rx_byte;
  endtask

  // ------------------------------------------------------------
  // reply in, optionally stalling every other cycle
  // ------------------------------------------------------------
  task automatic recv(input logic stall);
    int seen;
    seen    = 0;
    reply_q = {};
    for (int c = 0; c < 300; c++) begin
      @(posedge clk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        reply_q.push_back(tx_byte);
        seen = 1;
      end
      if (seen == 1 && tx_valid !== 1'b1 && tx_drive_en !== 1'b1) begin
        break;
      end
      #2;
      tx_ready = stall ? ~tx_ready : 1'b1;
    end
    #2;
    tx_ready = 1'b0;
  endtask
endmodule

// File: tb_motion_cmd_frame_slave.sv
// testbench of the command frame slave: host model, executor stub, scenarios
// assumes the host model file is compiled before this one
`timescale 1ns/1ps
module tb_motion_cmd_frame_slave;
  logic        clk;
  logic        rst;
  logic        can_mode;
  logic  [7:0] module_addr;
  logic  [7:0] reply_addr;
  logic        store_mode;
  logic  [7:0] rx_byte;
  logic        rx_strobe;
  logic        rx_sof;
  logic        cmd_valid;
  logic  [7:0] cmd_number;
  logic  [7:0] cmd_type;
  logic  [7:0] cmd_bank;
  logic [31:0] cmd_value;
  logic        cmd_store;
  logic        exec_done;
  logic  [7:0] exec_status;
  logic [31:0] exec_value;
  logic  [7:0] tx_byte;
  logic        tx_valid;
  logic        tx_ready;
  logic        tx_drive_en;
  logic        frame_error;
  int          fail_count;
  int          samples_checked;
  int          cmd_seen;
  int          err_seen;
  int          cycles;
  bit          pending;

  mcfs_frame_slave u_mcfs_frame_slave (
    .clk(clk), .rst(rst), .can_mode(can_mode), .module_addr(module_addr),
    .reply_addr(reply_addr), .store_mode(store_mode), .rx_byte(rx_byte),
    .rx_strobe(rx_strobe), .rx_sof(rx_sof), .cmd_valid(cmd_valid),
    .cmd_number(cmd_number), .cmd_type(cmd_type), .cmd_bank(cmd_bank),
    .cmd_value(cmd_value), .cmd_store(cmd_store), .exec_done(exec_done),
    .exec_status(exec_status), .exec_value(exec_value), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_drive_en(tx_drive_en),
    .frame_error(frame_error)
  );

  mcfs_host_model u_mcfs_host_model (
    .clk(clk), .rx_byte(rx_byte), .rx_strobe(rx_strobe), .rx_sof(rx_sof),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_drive_en(tx_drive_en)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic err(input string m);
    fail_count++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  task automatic cmp_bit(input logic g, input logic e);
    samples_checked++;
    if (g !== e) err("flag differs");
  endtask

  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) err($sformatf("byte %h, expected %h", g, e));
  endtask

  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) err($sformatf("word %h, expected %h", g, e));
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // executor stub and bus watch
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) begin
      cmd_seen++;
      repeat (3) @(posedge clk);
      #2;
      exec_done = 1'b1;
      @(posedge clk);
      #2;
      exec_done = 1'b0;
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (frame_error === 1'b1) err_seen++;
    if (tx_valid === 1'b1 && tx_drive_en !== 1'b1) err("byte offered, bus not driven");
    if (tx_drive_en === 1'b1 && !pending) err("bus driven with no command");
    if (cycles == 20000) begin
      err("timeout");
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // one command and its reply, judged
  // ------------------------------------------------------------
  task automatic run(input logic [7:0] cmd, input logic [7:0] typ,
                     input logic [31:0] val, input logic [7:0] bad,
                     input logic stall, input logic [7:0] est, input logic [31:0] ev);
    logic [71:0] f;
    logic  [7:0] s;
    logic  [7:0] exp_q[$];
    int          c0;
    int          e0;
    c0 = cmd_seen;
    e0 = err_seen;
    f  = {module_addr, cmd, typ, 8'h02, val, 8'h00};
    s  = 8'h00;
    for (int i = 0; i < 8; i++) s += f[71-8*i -: 8];
    f[7:0] = s + bad;
    if (can_mode) f = {cmd, typ, 8'h02, val, 16'h0000};
    pending = 1'b1;
    u_mcfs_host_model.send(f, can_mode ? 7 : 9);
    u_mcfs_host_model.recv(stall);
    pending = 1'b0;
    cmp_word(32'(cmd_seen - c0), (bad == 8'h00) ? 32'h0000_0001 : 32'h0000_0000);
    cmp_word(32'(err_seen - e0), (bad == 8'h00) ? 32'h0000_0000 : 32'h0000_0001);
    if (bad == 8'h00) begin
      cmp_byte(cmd_number, cmd);
      cmp_byte(cmd_type, typ);
      cmp_byte(cmd_bank, 8'h02);
      cmp_word(cmd_value, val);
      cmp_bit(cmd_store, store_mode);
    end
    exp_q = {est, cmd, ev[31:24], ev[23:16], ev[15:8], ev[7:0]};
    if (!can_mode) begin
      exp_q = {reply_addr, module_addr, exp_q};
      s = 8'h00;
      foreach (exp_q[i]) s += exp_q[i];
      exp_q.push_back(s);
    end
    cmp_word(32'(u_mcfs_host_model.reply_q.size()), 32'(exp_q.size()));
    foreach (exp_q[i]) begin
      if (i < u_mcfs_host_model.reply_q.size()) cmp_byte(u_mcfs_host_model.reply_q[i], exp_q[i]);
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_plain();
    exec_status = mcfs_pkg::ST_OK;
    exec_value  = 32'hA5C3_0F01;
    run(8'h05, 8'h04, 32'h8123_45FE, 8'h00, 1'b1, mcfs_pkg::ST_OK, 32'hA5C3_0F01);
  endtask

  task automatic t_store();
    store_mode = 1'b1;
    run(8'h0B, 8'h01, 32'h0000_0010, 8'h00, 1'b0, mcfs_pkg::ST_STORED, exec_value);
    store_mode = 1'b0;
  endtask

  task automatic t_codes();
    for (int k = 1; k <= 6; k++) begin
      exec_status = 8'(k);
      run(8'(k), 8'hFF, 32'hFFFF_FFFF, 8'h00, 1'b0, 8'(k), exec_value);
    end
  endtask

  task automatic t_bad_sum();
    exec_status = mcfs_pkg::ST_OK;
    run(8'h06, 8'h03, 32'h1234_5678, 8'h01, 1'b1, mcfs_pkg::ST_BAD_CSUM, 32'h0000_0000);
  endtask

  task automatic t_foreign();
    int c0;
    c0 = cmd_seen;
    u_mcfs_host_model.send({~module_addr, 64'h0501_0000_0000_0000}, 9);
    repeat (40) @(posedge clk);
    cmp_word(32'(cmd_seen - c0), 32'h0000_0000);
    t_plain();
  endtask

  task automatic t_can();
    can_mode = 1'b1;
    run(8'h0A, 8'h00, 32'h0001_F400, 8'h00, 1'b1, mcfs_pkg::ST_OK, exec_value);
    run(8'h0A, 8'h00, 32'h0001_F400, 8'h00, 1'b0, mcfs_pkg::ST_OK, exec_value);
    can_mode = 1'b0;
  endtask

  initial begin
    rst         = 1'b1;
    can_mode    = 1'b0;
    module_addr = 8'h01;
    reply_addr  = 8'h02;
    store_mode  = 1'b0;
    exec_done   = 1'b0;
    exec_status = 8'h00;
    exec_value  = 32'h0000_0000;
    repeat (3) @(posedge clk);
    #2;
    rst = 1'b0;
    @(posedge clk);
    #2;
    cmp_bit(tx_drive_en, 1'b0);
    cmp_bit(tx_valid, 1'b0);
    t_plain();
    t_store();
    t_codes();
    t_bad_sum();
    t_foreign();
    t_can();
    wrap_up();
  end
endmodule
